// file: common/cse_consts.vh
// Functional notes
// - In stop mode the block can keep a small set of clocks running so an internal periodic wake can restart it.
// - With a debug host attached and the debug enable bit set, the oscillator is held on during stop mode.
// - A halt-to-debug command during stop with the oscillator held restarts the CPU clock and enters active background mode.
// - The background-enter opcode stops user fetch and execution and switches to active background mode.
// - After background-enter, user code resumes only on reset or a resume, single-step or tagged-resume command.
// - A user opcode replaced by background-enter acts as a software breakpoint that enters active background mode.
// - Add with carry loads the accumulator with accumulator plus operand plus carry in all its addressing modes.
// - Add without carry loads the accumulator with accumulator plus operand in all its addressing modes.
// - Opcode A7 adds a signed immediate to the stack pointer in 2 cycles without touching the flags.
// - Opcode AF adds a signed immediate to the index pair in 2 cycles without touching the flags.
// - Logical AND stores accumulator AND operand in the accumulator and clears the overflow flag.
// - Shift left uses opcodes 38/48/58/68/78/9E68 with 1 cycle register forms and 5/5/4/6 cycle memory forms.
// - Shift right uses opcodes 37/47/57/67/77/9E67 and its register forms take one cycle.
// - Opcode 24 branches by a relative displacement when carry is 0, always in 3 cycles, flags untouched.
// - Background-enter opcode 82 acts only when the debug enable bit is 1, then serves commands, at least 5 cycles.
`ifndef CSE_CONSTS_VH
`define CSE_CONSTS_VH
// ==========================================
// sequencer states
`define CSE_ST_RESET 4'h0
`define CSE_ST_FETCH 4'h1
`define CSE_ST_PREF 4'h2
`define CSE_ST_OP1 4'h3
`define CSE_ST_OP2 4'h4
`define CSE_ST_RD 4'h5
`define CSE_ST_WR 4'h6
`define CSE_ST_PAD 4'h7
`define CSE_ST_BG 4'h8
`define CSE_ST_STOP 4'h9
// ==========================================
// opcodes and opcode fields
`define CSE_OP_PREFIX 8'h9E
`define CSE_OP_BACKGROUND_ENTER_OP 8'h82
`define CSE_OP_AIS 8'hA7
`define CSE_OP_AIX 8'hAF
`define CSE_OP_BCC 8'h24
`define CSE_LN_ADC 4'h9
`define CSE_LN_ADD 4'hB
`define CSE_LN_AND 4'h4
`define CSE_LN_ASL 4'h8
`define CSE_LN_ASR 4'h7
// ==========================================
// alu classes, instruction kinds, address bases
`define CSE_ALU_ADC 3'h0
`define CSE_ALU_ADD 3'h1
`define CSE_ALU_AND 3'h2
`define CSE_ALU_ASL 3'h3
`define CSE_ALU_ASR 3'h4
`define CSE_K_ALU 3'h0
`define CSE_K_AIS 3'h1
`define CSE_K_AIX 3'h2
`define CSE_K_BCC 3'h3
`define CSE_K_BACKGROUND_ENTER_OP 3'h4
`define CSE_B_ABS 2'h0
`define CSE_B_HX 2'h1
`define CSE_B_SP 2'h2
// ==========================================
// bus cycles per instruction form
`define CSE_CYC_IMM 4'h2
`define CSE_CYC_DIR 4'h3
`define CSE_CYC_EXT 4'h4
`define CSE_CYC_IX2 4'h4
`define CSE_CYC_IX1 4'h3
`define CSE_CYC_IX 4'h3
`define CSE_CYC_SP2 4'h5
`define CSE_CYC_SP1 4'h4
`define CSE_CYC_SH_DIR 4'h5
`define CSE_CYC_SH_INH 4'h1
`define CSE_CYC_SH_IX1 4'h5
`define CSE_CYC_SH_IX 4'h4
`define CSE_CYC_SH_SP1 4'h6
`define CSE_CYC_ADJ 4'h2
`define CSE_CYC_BCC 4'h3
`define CSE_CYC_BACKGROUND_ENTER_OP 4'h5
`define CSE_CYC_ILL 4'h1
// ==========================================
// flag positions and reset values
`define CSE_CC_V 7
`define CSE_CC_H 4
`define CSE_CC_N 2
`define CSE_CC_Z 1
`define CSE_CC_C 0
`define CSE_RST_CCR 8'h68
`define CSE_RST_SP 16'h00FF
`define CSE_RST_PC 16'h0000
`endif

// file: src/cse_alu.v
`timescale 1ns/1ps
`include "cse_consts.vh"
module cse_alu (
  input wire [2:0] i_cls, // operation class
  input wire [7:0] i_a, // first operand
  input wire [7:0] i_b, // second operand
  input wire [7:0] i_ccr, // flags before
  output reg [7:0] o_res, // result
  output reg [7:0] o_ccr // flags after
);
  reg [8:0] sum;
  reg [4:0] hsum;
  reg cin;
  always @* begin
    sum = 9'h000;
    hsum = 5'h00;
    cin = 1'b0;
    o_res = i_a;
    o_ccr = i_ccr;
    case (i_cls)
      `CSE_ALU_ADC, `CSE_ALU_ADD: begin
        cin = (i_cls == `CSE_ALU_ADC) ? i_ccr[`CSE_CC_C] : 1'b0;
        sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
        hsum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
        o_res = sum[7:0];
        o_ccr[`CSE_CC_H] = hsum[4];
        o_ccr[`CSE_CC_C] = sum[8];
        o_ccr[`CSE_CC_V] = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
      end
      `CSE_ALU_AND: begin
        o_res = i_a & i_b;
        o_ccr[`CSE_CC_V] = 1'b0;
      end
      `CSE_ALU_ASL: begin
        o_res = {i_a[6:0], 1'b0};
        o_ccr[`CSE_CC_C] = i_a[7];
        o_ccr[`CSE_CC_V] = i_a[6] ^ i_a[7];
      end
      `CSE_ALU_ASR: begin
        o_res = {i_a[7], i_a[7:1]};
        o_ccr[`CSE_CC_C] = i_a[0];
        o_ccr[`CSE_CC_V] = i_a[7] ^ i_a[0];
      end
      default: begin
        o_res = i_a;
      end
    endcase
    o_ccr[`CSE_CC_N] = o_res[7];
    o_ccr[`CSE_CC_Z] = (o_res == 8'h00);
  end
endmodule

// file: src/cse_exec.v
`timescale 1ns/1ps
`include "cse_consts.vh"
module cse_exec #(
  parameter [15:0] RESET_PC = `CSE_RST_PC
) (
  input wire i_clk, // bus clock
  input wire i_arst_n, // async reset, low
  input wire [7:0] i_mem_rdata, // read data for o_mem_addr
  input wire i_debug_enable_bit, // debug enable level
  input wire i_host_attached, // host on debug_wire_pin
  input wire i_reset_to_bg, // strap: leave reset in background
  input wire i_bg_cmd_halt, // halt-to-debug command pulse
  input wire i_bg_cmd_resume, // resume command pulse
  input wire i_bg_cmd_step, // single_step_cmd pulse
  input wire i_bg_cmd_tagged, // tagged_resume_cmd pulse
  input wire i_stop_req, // enter stop at next boundary
  input wire i_stop_clk_keep_en, // keep minimal clocks in stop
  input wire i_wake, // wake from stop pulse
  output wire [15:0] o_mem_addr, // bus address
  output wire o_mem_rd, // read cycle
  output wire o_mem_wr, // write cycle
  output wire [7:0] o_mem_wdata, // write data
  output wire [7:0] o_acc, // accumulator
  output wire [15:0] o_hx, // index pair
  output wire [15:0] o_sp, // stack_pointer
  output wire [15:0] o_pc, // program counter
  output wire [7:0] o_ccr, // condition_flags
  output wire o_active_bg, // in active background
  output wire o_stopped, // in stop mode
  output wire o_cpu_clk_en, // cpu clock running
  output wire o_osc_keep, // hold oscillator on
  output wire o_min_clk_run, // minimal clocks kept in stop
  output wire o_insn_done, // instruction retired pulse
  output wire o_illegal // unknown opcode pulse
);
  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [3:0] need_q;
  reg [7:0] op_q;
  reg pre_q;
  reg [7:0] hi_q;
  reg [15:0] ea_q;
  reg [7:0] res_q;
  reg [7:0] acc_q;
  reg [15:0] hx_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg [7:0] ccr_q;
  reg step_q;
  reg done_q;
  reg ill_q;

  // ==========================================
  // decode of the opcode in flight
  wire fetching = (st_q == `CSE_ST_FETCH) || (st_q == `CSE_ST_PREF);
  wire [7:0] cur_op = fetching ? i_mem_rdata : op_q;
  wire cur_pre = (st_q == `CSE_ST_PREF) ? 1'b1 : pre_q;
  wire [3:0] hn = cur_op[7:4];
  wire [3:0] ln = cur_op[3:0];
  wire ln_alu = (ln == `CSE_LN_ADC) || (ln == `CSE_LN_ADD) ||
                (ln == `CSE_LN_AND);
  wire ln_sh = (ln == `CSE_LN_ASL) || (ln == `CSE_LN_ASR);
  reg d_ok;
  reg d_mem;
  reg d_rmw;
  reg d_shx;
  reg [1:0] d_nb;
  reg [1:0] d_base;
  reg [2:0] d_cls;
  reg [2:0] d_kind;
  reg [3:0] d_need;
  always @* begin
    d_ok = 1'b0;
    d_mem = 1'b0;
    d_rmw = 1'b0;
    d_shx = 1'b0;
    d_nb = 2'h0;
    d_base = `CSE_B_ABS;
    d_kind = `CSE_K_ALU;
    d_need = `CSE_CYC_ILL;
    d_cls = (ln == `CSE_LN_ADC) ? `CSE_ALU_ADC :
            (ln == `CSE_LN_ADD) ? `CSE_ALU_ADD :
            (ln == `CSE_LN_AND) ? `CSE_ALU_AND :
            (ln == `CSE_LN_ASL) ? `CSE_ALU_ASL : `CSE_ALU_ASR;
    if (!cur_pre) begin
      if (cur_op == `CSE_OP_BACKGROUND_ENTER_OP) begin
        d_ok = 1'b1;
        d_kind = `CSE_K_BACKGROUND_ENTER_OP;
        d_need = `CSE_CYC_BACKGROUND_ENTER_OP;
      end else if (cur_op == `CSE_OP_AIS) begin
        d_ok = 1'b1;
        d_kind = `CSE_K_AIS;
        d_nb = 2'h1;
        d_need = `CSE_CYC_ADJ;
      end else if (cur_op == `CSE_OP_AIX) begin
        d_ok = 1'b1;
        d_kind = `CSE_K_AIX;
        d_nb = 2'h1;
        d_need = `CSE_CYC_ADJ;
      end else if (cur_op == `CSE_OP_BCC) begin
        d_ok = 1'b1;
        d_kind = `CSE_K_BCC;
        d_nb = 2'h1;
        d_need = `CSE_CYC_BCC;
      end else if (ln_alu && hn >= 4'hA) begin
        d_ok = 1'b1;
        case (hn)
          4'hA: begin
            d_nb = 2'h1;
            d_need = `CSE_CYC_IMM;
          end
          4'hB: begin
            d_nb = 2'h1;
            d_mem = 1'b1;
            d_need = `CSE_CYC_DIR;
          end
          4'hC: begin
            d_nb = 2'h2;
            d_mem = 1'b1;
            d_need = `CSE_CYC_EXT;
          end
          4'hD: begin
            d_nb = 2'h2;
            d_mem = 1'b1;
            d_base = `CSE_B_HX;
            d_need = `CSE_CYC_IX2;
          end
          4'hE: begin
            d_nb = 2'h1;
            d_mem = 1'b1;
            d_base = `CSE_B_HX;
            d_need = `CSE_CYC_IX1;
          end
          default: begin
            d_mem = 1'b1;
            d_base = `CSE_B_HX;
            d_need = `CSE_CYC_IX;
          end
        endcase
      end else if (ln_sh && hn >= 4'h3 && hn <= 4'h7) begin
        d_ok = 1'b1;
        d_rmw = (hn != 4'h4) && (hn != 4'h5);
        d_mem = d_rmw;
        case (hn)
          4'h3: begin
            d_nb = 2'h1;
            d_need = `CSE_CYC_SH_DIR;
          end
          4'h4: d_need = `CSE_CYC_SH_INH;
          4'h5: begin
            d_shx = 1'b1;
            d_need = `CSE_CYC_SH_INH;
          end
          4'h6: begin
            d_nb = 2'h1;
            d_base = `CSE_B_HX;
            d_need = `CSE_CYC_SH_IX1;
          end
          default: begin
            d_base = `CSE_B_HX;
            d_need = `CSE_CYC_SH_IX;
          end
        endcase
      end
    end else if (ln_alu && (hn == 4'hD || hn == 4'hE)) begin
      d_ok = 1'b1;
      d_mem = 1'b1;
      d_base = `CSE_B_SP;
      d_nb = (hn == 4'hD) ? 2'h2 : 2'h1;
      d_need = (hn == 4'hD) ? `CSE_CYC_SP2 : `CSE_CYC_SP1;
    end else if (ln_sh && hn == 4'h6) begin
      d_ok = 1'b1;
      d_mem = 1'b1;
      d_rmw = 1'b1;
      d_nb = 2'h1;
      d_base = `CSE_B_SP;
      d_need = `CSE_CYC_SH_SP1;
    end
  end

  // ==========================================
  // alu and operand steering
  wire is_shift = (d_cls == `CSE_ALU_ASL) || (d_cls == `CSE_ALU_ASR);
  wire [7:0] alu_a = (is_shift && d_rmw) ? i_mem_rdata :
                     d_shx ? hx_q[7:0] : acc_q;
  wire [7:0] alu_res;
  wire [7:0] alu_ccr;
  cse_alu u_alu (
    .i_cls(d_cls),
    .i_a(alu_a),
    .i_b(i_mem_rdata),
    .i_ccr(ccr_q),
    .o_res(alu_res),
    .o_ccr(alu_ccr)
  );
  wire [15:0] sext = {{8{i_mem_rdata[7]}}, i_mem_rdata};
  wire [15:0] base_v = (d_base == `CSE_B_HX) ? hx_q :
                       (d_base == `CSE_B_SP) ? sp_q : 16'h0000;

  // ==========================================
  // cycle padding and instruction end
  // every form is stretched to its table count so timing never
  // depends on how few states the sequencer happens to need
  wire [3:0] done_cnt = (st_q == `CSE_ST_FETCH) ? 4'h1 : cnt_q + 4'h1;
  wire [3:0] need_eff = fetching ? d_need : need_q;
  wire reached = (done_cnt >= need_eff);
  wire bg_take = (d_kind == `CSE_K_BACKGROUND_ENTER_OP) && d_ok && i_debug_enable_bit;
  wire [3:0] after_st = (bg_take || step_q || i_bg_cmd_halt) ?
                        `CSE_ST_BG :
                        i_stop_req ? `CSE_ST_STOP : `CSE_ST_FETCH;
  wire [3:0] fin_st = reached ? after_st : `CSE_ST_PAD;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= `CSE_ST_RESET;
      cnt_q <= 4'h0;
      need_q <= 4'h1;
      op_q <= 8'h00;
      pre_q <= 1'b0;
      hi_q <= 8'h00;
      ea_q <= 16'h0000;
      res_q <= 8'h00;
      acc_q <= 8'h00;
      hx_q <= 16'h0000;
      sp_q <= `CSE_RST_SP;
      pc_q <= RESET_PC;
      ccr_q <= `CSE_RST_CCR;
      step_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      cnt_q <= done_cnt;
      case (st_q)
        `CSE_ST_RESET: begin
          // strap caught on the first edge after release
          st_q <= i_reset_to_bg ? `CSE_ST_BG : `CSE_ST_FETCH;
        end
        `CSE_ST_FETCH, `CSE_ST_PREF: begin
          pc_q <= pc_q + 16'h0001;
          op_q <= i_mem_rdata;
          pre_q <= (st_q == `CSE_ST_PREF);
          need_q <= d_need;
          if (st_q == `CSE_ST_FETCH && i_mem_rdata == `CSE_OP_PREFIX) begin
            st_q <= `CSE_ST_PREF;
          end else if (!d_ok) begin
            ill_q <= 1'b1;
            done_q <= reached;
            st_q <= fin_st;
          end else if (d_nb != 2'h0) begin
            st_q <= `CSE_ST_OP1;
          end else if (d_mem) begin
            ea_q <= hx_q;
            st_q <= `CSE_ST_RD;
          end else begin
            if (d_kind == `CSE_K_ALU && d_shx) begin
              hx_q[7:0] <= alu_res;
              ccr_q <= alu_ccr;
            end else if (d_kind == `CSE_K_ALU) begin
              acc_q <= alu_res;
              ccr_q <= alu_ccr;
            end
            done_q <= reached;
            st_q <= fin_st;
          end
        end
        `CSE_ST_OP1: begin
          pc_q <= pc_q + 16'h0001;
          hi_q <= i_mem_rdata;
          if (d_kind == `CSE_K_AIS) begin
            sp_q <= sp_q + sext;
            done_q <= reached;
            st_q <= fin_st;
          end else if (d_kind == `CSE_K_AIX) begin
            hx_q <= hx_q + sext;
            done_q <= reached;
            st_q <= fin_st;
          end else if (d_kind == `CSE_K_BCC) begin
            if (!ccr_q[`CSE_CC_C]) begin
              pc_q <= pc_q + 16'h0001 + sext;
            end
            done_q <= reached;
            st_q <= fin_st;
          end else if (d_nb == 2'h2) begin
            st_q <= `CSE_ST_OP2;
          end else if (d_mem) begin
            ea_q <= base_v + {8'h00, i_mem_rdata};
            st_q <= `CSE_ST_RD;
          end else begin
            acc_q <= alu_res;
            ccr_q <= alu_ccr;
            done_q <= reached;
            st_q <= fin_st;
          end
        end
        `CSE_ST_OP2: begin
          pc_q <= pc_q + 16'h0001;
          ea_q <= base_v + {hi_q, i_mem_rdata};
          st_q <= `CSE_ST_RD;
        end
        `CSE_ST_RD: begin
          ccr_q <= alu_ccr;
          if (d_rmw) begin
            res_q <= alu_res;
            st_q <= `CSE_ST_WR;
          end else begin
            acc_q <= alu_res;
            done_q <= reached;
            st_q <= fin_st;
          end
        end
        `CSE_ST_WR, `CSE_ST_PAD: begin
          done_q <= reached;
          st_q <= fin_st;
        end
        `CSE_ST_BG: begin
          // only these commands release the core to user code
          step_q <= i_bg_cmd_step;
          if (i_bg_cmd_resume || i_bg_cmd_tagged || i_bg_cmd_step) begin
            st_q <= `CSE_ST_FETCH;
          end
        end
        `CSE_ST_STOP: begin
          if (i_bg_cmd_halt && o_osc_keep) begin
            st_q <= `CSE_ST_BG;
          end else if (i_wake) begin
            st_q <= `CSE_ST_FETCH;
          end
        end
        default: st_q <= `CSE_ST_FETCH;
      endcase
    end
  end

  // ==========================================
  // outputs
  wire data_cyc = (st_q == `CSE_ST_RD) || (st_q == `CSE_ST_WR);
  assign o_mem_addr = data_cyc ? ea_q : pc_q;
  assign o_mem_rd = fetching || (st_q == `CSE_ST_OP1) ||
                    (st_q == `CSE_ST_OP2) || (st_q == `CSE_ST_RD);
  assign o_mem_wr = (st_q == `CSE_ST_WR);
  assign o_mem_wdata = res_q;
  assign o_acc = acc_q;
  assign o_hx = hx_q;
  assign o_sp = sp_q;
  assign o_pc = pc_q;
  assign o_ccr = ccr_q;
  assign o_active_bg = (st_q == `CSE_ST_BG);
  assign o_stopped = (st_q == `CSE_ST_STOP);
  assign o_cpu_clk_en = !o_stopped;
  assign o_osc_keep = o_stopped && i_host_attached &&
                      i_debug_enable_bit;
  assign o_min_clk_run = o_stopped && i_stop_clk_keep_en;
  assign o_insn_done = done_q;
  assign o_illegal = ill_q;
endmodule

// file: testbench/cse_exec_monitor.sv
`timescale 1ns/1ps
module cse_exec_monitor (
  input wire i_clk, // bus clock
  input wire i_arst_n, // async reset, low
  input wire [7:0] i_mem_rdata, // opcode bus
  input wire i_debug_enable_bit, // debug enable
  input wire i_host_attached, // host present
  input wire i_bg_cmd_halt, // halt pulse
  input wire i_bg_cmd_resume, // resume pulse
  input wire i_bg_cmd_step, // step pulse
  input wire i_bg_cmd_tagged, // tagged pulse
  input wire i_stop_clk_keep_en, // keep clocks
  input wire o_mem_rd, // read cycle
  input wire [7:0] o_ccr, // flags
  input wire o_active_bg, // background
  input wire o_stopped, // stop mode
  input wire o_cpu_clk_en, // cpu clock
  input wire o_osc_keep, // oscillator hold
  input wire o_min_clk_run, // minimal clocks
  input wire o_insn_done // retire pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================
  // opcode fetch that follows a retire
  sequence s_fetch(op);
    o_insn_done && o_mem_rd && i_mem_rdata == op;
  endsequence
  sequence s_bg(en);
    s_fetch(8'h82) ##0 i_debug_enable_bit == en;
  endsequence
  sequence s_keep2;
    (!o_insn_done && $stable(o_ccr)) ##1 (o_insn_done && $stable(o_ccr));
  endsequence
  // ==========================================
  // cycle counts and flags
  adj_sp_a: assert property (
    s_fetch(8'hA7) |=> s_keep2) else $error("stack adjust wrong");
  adj_hx_a: assert property (
    s_fetch(8'hAF) |=> s_keep2) else $error("index adjust wrong");
  branch_cc_a: assert property (
    s_fetch(8'h24) |=> (!o_insn_done && $stable(o_ccr))[*2]
      ##1 (o_insn_done && $stable(o_ccr))) else $error("branch timing");
  adc_imm_a: assert property (
    s_fetch(8'hA9) |=> !o_insn_done ##1 o_insn_done)
    else $error("add carry timing");
  shift_reg_a: assert property (
    o_insn_done && o_mem_rd && i_mem_rdata inside {8'h47, 8'h48, 8'h57,
      8'h58} |=> o_insn_done) else $error("register shift timing");
  shift_dir_a: assert property (
    s_fetch(8'h38) |=> (!o_insn_done)[*4] ##1 o_insn_done)
    else $error("memory shift timing");
  and_ovf_a: assert property (
    s_fetch(8'hA4) |-> ##2 !o_ccr[7]) else $error("and left overflow");
  // ==========================================
  // background and stop
  bg_enter_a: assert property (
    s_bg(1'b1) |=> (!o_active_bg)[*4] ##1 (o_active_bg && o_insn_done))
    else $error("background entry wrong");
  bg_skip_a: assert property (
    s_bg(1'b0) |=> (!o_insn_done)[*4] ##1 (o_insn_done && !o_active_bg))
    else $error("disabled background op wrong");
  bg_hold_a: assert property (
    o_active_bg && !i_bg_cmd_resume && !i_bg_cmd_step && !i_bg_cmd_tagged
      |=> o_active_bg) else $error("left background alone");
  bg_leave_a: assert property (
    o_active_bg && (i_bg_cmd_resume || i_bg_cmd_tagged)
      |=> !o_active_bg && o_mem_rd) else $error("resume not taken");
  stop_halt_a: assert property (
    o_stopped && o_osc_keep && i_bg_cmd_halt
      |=> o_active_bg && !o_stopped && o_cpu_clk_en)
    else $error("halt in stop not taken");
  osc_keep_a: assert property (
    o_osc_keep == (o_stopped && i_host_attached && i_debug_enable_bit))
    else $error("oscillator hold wrong");
  min_clk_a: assert property (
    o_min_clk_run == (o_stopped && i_stop_clk_keep_en))
    else $error("minimal clock wrong");
endmodule

// file: testbench/cse_host_model.sv
`timescale 1ns/1ps
module cse_host_model (
  input wire i_clk, // bus clock
  output reg o_host_attached, // host on debug_wire_pin
  output reg o_debug_enable_bit, // debug enable level
  output reg [3:0] o_cmd // halt, resume, step, tagged
);
  initial begin
    o_host_attached = 1'b1;
    o_debug_enable_bit = 1'b1;
    o_cmd = 4'h0;
  end
  // ==========================================
  // serial commands arrive as one-cycle pulses
  task send(input int k);
    @(negedge i_clk);
    o_cmd[k] = 1'b1;
    @(negedge i_clk);
    o_cmd = 4'h0;
  endtask
  // level changes land in the caller's falling-edge time step, so a
  // one-cycle instruction right after a check is not skipped
  task set_en(input bit e);
    o_debug_enable_bit = e;
  endtask
  task set_att(input bit a);
    o_host_attached = a;
  endtask
endmodule

// file: testbench/test_cse_exec.sv
`timescale 1ns/1ps
module test_cse_exec;
  logic i_clk, i_arst_n, i_stop_req, i_stop_clk_keep_en, i_wake;
  logic i_reset_to_bg;
  wire [7:0] i_mem_rdata, o_mem_wdata, o_acc, o_ccr;
  wire i_host_attached, i_debug_enable_bit;
  wire [3:0] cmd;
  wire [15:0] o_mem_addr, o_hx, o_sp, o_pc;
  wire o_mem_rd, o_mem_wr, o_active_bg, o_stopped, o_cpu_clk_en;
  wire o_osc_keep, o_min_clk_run, o_insn_done, o_illegal;
  logic [7:0] mem [0:255];
  int err_count, check_count, i;
  logic [7:0] prog [0:34] = '{8'hAB, 8'h05, 8'hA9, 8'hFC, 8'hA9, 8'h00,
    8'hA9, 8'h7F, 8'hA4, 8'hC1, 8'h48, 8'h47, 8'hA7, 8'hFE, 8'hAF, 8'h10,
    8'h24, 8'h02, 8'hA9, 8'h55, 8'h38, 8'h80, 8'h24, 8'h10, 8'h82, 8'hAB,
    8'h01, 8'h82, 8'h58, 8'h57, 8'h82, 8'hAB, 8'h01, 8'h24, 8'hFE};
  // accumulator, flags, next fetch address after each retire
  logic [31:0] tbl [0:16] = '{32'h05680002, 32'h01790004, 32'h02680006,
    32'h81FC0008, 32'h817C000A, 32'h02F9000B, 32'h0178000C, 32'h0178000E,
    32'h01780010, 32'h01780014, 32'h017D0016, 32'h017D0018, 32'h0268001B,
    32'h0268001C, 32'h0268001D, 32'h0268001E, 32'h03680021};

  cse_exec cse_exec_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_mem_rdata(i_mem_rdata), .i_debug_enable_bit(i_debug_enable_bit),
    .i_host_attached(i_host_attached), .i_reset_to_bg(i_reset_to_bg),
    .i_bg_cmd_halt(cmd[0]), .i_bg_cmd_resume(cmd[1]),
    .i_bg_cmd_step(cmd[2]), .i_bg_cmd_tagged(cmd[3]),
    .i_stop_req(i_stop_req), .i_stop_clk_keep_en(i_stop_clk_keep_en),
    .i_wake(i_wake), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc),
    .o_hx(o_hx), .o_sp(o_sp), .o_pc(o_pc), .o_ccr(o_ccr),
    .o_active_bg(o_active_bg), .o_stopped(o_stopped),
    .o_cpu_clk_en(o_cpu_clk_en), .o_osc_keep(o_osc_keep),
    .o_min_clk_run(o_min_clk_run), .o_insn_done(o_insn_done),
    .o_illegal(o_illegal));
  cse_host_model host_i (.i_clk(i_clk), .o_host_attached(i_host_attached),
    .o_debug_enable_bit(i_debug_enable_bit), .o_cmd(cmd));

  // ==========================================
  // zero-wait memory, answers in the same cycle
  assign i_mem_rdata = mem[o_mem_addr[7:0]];
  always @(posedge i_clk) begin
    if (o_mem_wr === 1'b1)
      mem[o_mem_addr[7:0]] <= o_mem_wdata;
  end
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ==========================================
  // checking tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // s selects retire pulse (0) or stop level (1); bounded wait
  task wsig(input int s);
    int n;
    n = 0;
    @(negedge i_clk);
    while ((s == 0 ? o_insn_done : o_stopped) !== 1'b1 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 60) chk(32'h1, 32'h0);
  endtask
  task row(input int k);
    wsig(0);
    chk({o_acc, o_ccr, o_mem_addr}, tbl[k]);
  endtask
  task end_of_test;
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
  // ==========================================
  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_stop_req = 1'b0;
    i_stop_clk_keep_en = 1'b1;
    i_wake = 1'b0;
    i_reset_to_bg = 1'b0;
    for (i = 0; i < 256; i++) mem[i] = 8'h00;
    for (i = 0; i < 35; i++) mem[i] = prog[i];
    mem[8'h80] = 8'hC0;
    repeat (6) @(negedge i_clk);
    chk({o_acc, o_ccr, o_sp}, 32'h006800FF);
    i_arst_n = 1'b1;
    for (i = 0; i < 12; i++) row(i);
    chk({o_sp, o_hx}, 32'h00FD0010);
    chk(mem[8'h80], 32'h80);
    wsig(0);
    chk({o_active_bg, o_pc}, 32'h10019);
    repeat (8) @(negedge i_clk);
    chk({o_active_bg, o_mem_rd, o_acc}, 32'h201);
    host_i.set_en(1'b0);
    host_i.send(1);
    row(12);
    row(13);
    chk(o_active_bg, 32'h0);
    host_i.set_en(1'b1);
    row(14);
    chk(o_hx, 32'h0020);
    row(15);
    chk(o_hx, 32'h0010);
    wsig(0);
    chk(o_active_bg, 32'h1);
    host_i.send(2);
    row(16);
    repeat (3) @(negedge i_clk);
    chk(o_active_bg, 32'h1);
    host_i.send(3);
    wsig(0);
    chk({o_active_bg, o_mem_addr}, 32'h0021);
    // stop with the host holding the oscillator, then halt out of it
    i_stop_req = 1'b1;
    wsig(1);
    i_stop_req = 1'b0;
    chk({o_cpu_clk_en, o_osc_keep, o_min_clk_run}, 32'h3);
    host_i.send(0);
    chk({o_active_bg, o_stopped}, 32'h2);
    host_i.send(1);
    host_i.set_en(1'b0);
    i_stop_clk_keep_en = 1'b0;
    i_stop_req = 1'b1;
    wsig(1);
    i_stop_req = 1'b0;
    chk({o_osc_keep, o_min_clk_run}, 32'h0);
    // enable back on but host gone: no oscillator hold, halt refused
    host_i.set_att(1'b0);
    host_i.set_en(1'b1);
    host_i.send(0);
    chk({o_active_bg, o_stopped, o_osc_keep}, 32'h2);
    i_wake = 1'b1;
    @(negedge i_clk);
    i_wake = 1'b0;
    wsig(0);
    chk(o_stopped, 32'h0);
    // ==========================================
    // reset again with the strap high: core must wait in background
    i_arst_n = 1'b0;
    i_reset_to_bg = 1'b1;
    mem[0] = 8'h01;
    @(negedge i_clk);
    chk({o_acc, o_ccr, o_sp}, 32'h006800FF);
    chk({o_hx, o_pc}, 32'h00000000);
    i_arst_n = 1'b1;
    @(negedge i_clk);
    chk({o_active_bg, o_mem_rd}, 32'h2);
    host_i.send(1);
    wsig(0);
    chk({o_illegal, o_mem_addr}, 32'h10001);
    end_of_test;
  end
endmodule

bind cse_exec cse_exec_monitor cse_exec_monitor_i (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_mem_rdata(i_mem_rdata),
  .i_debug_enable_bit(i_debug_enable_bit),
  .i_host_attached(i_host_attached), .i_bg_cmd_halt(i_bg_cmd_halt),
  .i_bg_cmd_resume(i_bg_cmd_resume), .i_bg_cmd_step(i_bg_cmd_step),
  .i_bg_cmd_tagged(i_bg_cmd_tagged),
  .i_stop_clk_keep_en(i_stop_clk_keep_en), .o_mem_rd(o_mem_rd),
  .o_ccr(o_ccr), .o_active_bg(o_active_bg), .o_stopped(o_stopped),
  .o_cpu_clk_en(o_cpu_clk_en), .o_osc_keep(o_osc_keep),
  .o_min_clk_run(o_min_clk_run), .o_insn_done(o_insn_done));
